// ===== src/ring_monitor_defs.svh
// Register offsets, reset values and timing counts for the ring beacon monitor
`ifndef RING_MONITOR_DEFS_SVH
`define RING_MONITOR_DEFS_SVH

`define OFS_BEACON_STATE_PAIR   8'h6e
`define OFS_TIMEOUT_LOW         8'h70
`define OFS_TIMEOUT_HIGH        8'h72
`define OFS_P1_STAMP_LOW        8'h74
`define OFS_P1_STAMP_HIGH       8'h76
`define OFS_P2_STAMP_LOW        8'h78
`define OFS_P2_STAMP_HIGH       8'h7a
`define OFS_P1_NBR_SRC_0        8'h7c
`define OFS_P1_NBR_SRC_1        8'h7e
`define OFS_P1_NBR_SRC_2        8'h80
`define OFS_RING_CONTROL        8'h6c
`define OFS_SWITCH_EVENT        8'h5e

// Ring control bit positions
`define CTL_P1_TIMEOUT_ENABLE   7
`define CTL_P2_TIMEOUT_ENABLE   8
`define CTL_CLEAR_SOURCE_IDS    11

// Switch event bit positions
`define EVT_P1_STATE_CHANGE     0
`define EVT_P2_STATE_CHANGE     1
`define EVT_P1_TIMEOUT          2
`define EVT_P2_TIMEOUT          3

`define RESET_16                16'h0000
`define RESET_32                32'h0000_0000

// Timing: system clock and beacon timer tick rates
`define SYS_CLOCK_MHZ           100
`define TIMEOUT_TICK_MHZ        50
`define TIMEOUT_TICK_DIVIDE     (`SYS_CLOCK_MHZ / `TIMEOUT_TICK_MHZ)

`endif

// ===== src/ring_monitor_pkg.sv
// Types shared by the ring beacon monitor
package ring_monitor_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic        port2;
      logic        crc_ok;
      logic [47:0] src_mac;
      logic [7:0]  state_flags;
   } beacon_frame_t;

   typedef struct packed {
      logic        valid;
      logic        port2;
      logic [47:0] src_mac;
   } neighbor_frame_t;

   typedef enum logic [1:0] {
      timer_idle   = 2'b00,
      timer_run    = 2'b01
   } timer_state_t;

endpackage

// ===== src/ring_beacon_supervision_monitor.sv
// Ring beacon supervision monitor: state capture, timeouts, stamps, neighbor record
`timescale 1ns/1ns
`include "ring_monitor_defs.svh"

module ring_beacon_supervision_monitor
(
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire ring_monitor_pkg::reg_req_t        reg_req,
   output logic [15:0]                            reg_rdata,
   input  wire ring_monitor_pkg::beacon_frame_t   beacon,
   input  wire ring_monitor_pkg::neighbor_frame_t neighbor,
   input  wire logic [47:0]                       supervisor_mac,
   output logic [3:0]                             event_flags,
   output logic [7:0]                             port1_supervisor_state_byte,
   output logic [7:0]                             port2_supervisor_state_byte
);
   import ring_monitor_pkg::*;

   logic [31:0]  shared_timeout_reload;
   logic [15:0]  ring_control;
   logic [31:0]  free_counter;
   logic [31:0]  port1_arrival_stamp;
   logic [31:0]  port2_arrival_stamp;
   logic [47:0]  port1_neighbor_src;
   logic         tick_phase;
   logic [1:0]   enable_q;
   logic [31:0]  timer        [2];
   logic [1:0]   timer_zero;
   logic [1:0]   beacon_hit;
   logic [1:0]   state_change;
   logic [3:0]   next_events;
   logic         port1_timeout_enable;
   logic         port2_timeout_enable;
   logic         supervisor_beacon;
   logic         event_read;
   logic [15:0]  next_rdata;

   assign port1_timeout_enable = ring_control[`CTL_P1_TIMEOUT_ENABLE];
   assign port2_timeout_enable = ring_control[`CTL_P2_TIMEOUT_ENABLE];

   assign supervisor_beacon = beacon.valid && (beacon.src_mac == supervisor_mac);

   function automatic logic is_write(input reg_req_t req, input logic [7:0] ofs);
      is_write = req.wr && (req.addr == ofs);
   endfunction

   // Host register writes
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         shared_timeout_reload <= `RESET_32;
         ring_control          <= `RESET_16;
      end
      else
      begin
         if (is_write(reg_req, `OFS_TIMEOUT_LOW))
         begin
            shared_timeout_reload[15:0] <= reg_req.wdata;
         end
         if (is_write(reg_req, `OFS_TIMEOUT_HIGH))
         begin
            shared_timeout_reload[31:16] <= reg_req.wdata;
         end
         if (is_write(reg_req, `OFS_RING_CONTROL))
         begin
            ring_control <= reg_req.wdata;
         end
         else
         begin
            ring_control[`CTL_CLEAR_SOURCE_IDS] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         free_counter <= `RESET_32;
      end
      else
      begin
         free_counter <= free_counter + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tick_phase <= 1'b0;
      end
      else
      begin
         tick_phase <= ~tick_phase;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         enable_q <= 2'b00;
      end
      else
      begin
         enable_q <= {port2_timeout_enable, port1_timeout_enable};
      end
   end

   // Per-port timeout timers
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_timer
         logic en;
         assign en            = (p == 0) ? port1_timeout_enable : port2_timeout_enable;
         assign beacon_hit[p] = supervisor_beacon && beacon.crc_ok && (beacon.port2 == (p == 1));
         assign timer_zero[p] = en && enable_q[p] && (timer[p] == `RESET_32) && tick_phase;

         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               timer[p] <= `RESET_32;
            end
            else if (!en)
            begin
               timer[p] <= timer[p];
            end
            else if (!enable_q[p] || beacon_hit[p] || timer_zero[p])
            begin
               timer[p] <= shared_timeout_reload;
            end
            else if (tick_phase && timer[p] != `RESET_32)
            begin
               timer[p] <= timer[p] - 32'h0000_0001;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         port1_supervisor_state_byte <= 8'h00;
         port2_supervisor_state_byte <= 8'h00;
      end
      else if (supervisor_beacon)
      begin
         if (!beacon.port2)
         begin
            port1_supervisor_state_byte <= beacon.state_flags;
         end
         else
         begin
            port2_supervisor_state_byte <= beacon.state_flags;
         end
      end
   end

   assign state_change[0] = supervisor_beacon && !beacon.port2
                            && (beacon.state_flags != port1_supervisor_state_byte);
   assign state_change[1] = supervisor_beacon && beacon.port2
                            && (beacon.state_flags != port2_supervisor_state_byte);

   // Event read clears flags; a new event wins over the clear
   assign event_read = reg_req.rd && (reg_req.addr == `OFS_SWITCH_EVENT);

   always_comb
   begin
      next_events = event_read ? 4'h0 : event_flags;
      next_events[`EVT_P1_STATE_CHANGE] = next_events[`EVT_P1_STATE_CHANGE] | state_change[0];
      next_events[`EVT_P2_STATE_CHANGE] = next_events[`EVT_P2_STATE_CHANGE] | state_change[1];
      next_events[`EVT_P1_TIMEOUT] = next_events[`EVT_P1_TIMEOUT] | timer_zero[0];
      next_events[`EVT_P2_TIMEOUT] = next_events[`EVT_P2_TIMEOUT] | timer_zero[1];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         event_flags <= 4'h0;
      end
      else
      begin
         event_flags <= next_events;
      end
   end

   // Timestamps; CRC not required for a snapshot
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         port1_arrival_stamp <= `RESET_32;
         port2_arrival_stamp <= `RESET_32;
      end
      else if (supervisor_beacon)
      begin
         if (!beacon.port2)
         begin
            port1_arrival_stamp <= free_counter;
         end
         else
         begin
            port2_arrival_stamp <= free_counter;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         port1_neighbor_src <= 48'h0000_0000_0000;
      end
      else if (ring_control[`CTL_CLEAR_SOURCE_IDS])
      begin
         port1_neighbor_src <= 48'h0000_0000_0000;
      end
      else if (neighbor.valid && !neighbor.port2)
      begin
         port1_neighbor_src <= neighbor.src_mac;
      end
   end

   // Read mux; plain reads, no latch, no side effect except event clear
   always_comb
   begin
      next_rdata = 16'h0000;
      case (reg_req.addr)
         `OFS_BEACON_STATE_PAIR:
            next_rdata = {port2_supervisor_state_byte, port1_supervisor_state_byte};
         `OFS_TIMEOUT_LOW:    next_rdata = shared_timeout_reload[15:0];
         `OFS_TIMEOUT_HIGH:   next_rdata = shared_timeout_reload[31:16];
         `OFS_P1_STAMP_LOW:   next_rdata = port1_arrival_stamp[15:0];
         `OFS_P1_STAMP_HIGH:  next_rdata = port1_arrival_stamp[31:16];
         `OFS_P2_STAMP_LOW:   next_rdata = port2_arrival_stamp[15:0];
         `OFS_P2_STAMP_HIGH:  next_rdata = port2_arrival_stamp[31:16];
         `OFS_P1_NBR_SRC_0:   next_rdata = port1_neighbor_src[15:0];
         `OFS_P1_NBR_SRC_1:   next_rdata = port1_neighbor_src[31:16];
         `OFS_P1_NBR_SRC_2:   next_rdata = port1_neighbor_src[47:32];
         `OFS_RING_CONTROL:   next_rdata = ring_control;
         `OFS_SWITCH_EVENT:   next_rdata = {12'h000, event_flags};
         default:             next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_req.rd)
      begin
         reg_rdata <= next_rdata;
      end
      else
      begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// ===== tb/ring_monitor_chk.sv
// Port checker for the ring beacon supervision monitor
`timescale 1ns/1ns
`include "ring_monitor_defs.svh"
module ring_monitor_chk
(
   input wire logic                              clk,
   input wire logic                              rst_n,
   input wire ring_monitor_pkg::reg_req_t        reg_req,
   input wire logic [15:0]                       reg_rdata,
   input wire ring_monitor_pkg::beacon_frame_t   beacon,
   input wire ring_monitor_pkg::neighbor_frame_t neighbor,
   input wire logic [47:0]                       supervisor_mac,
   input wire logic [3:0]                        event_flags,
   input wire logic [7:0]                        port1_supervisor_state_byte,
   input wire logic [7:0]                        port2_supervisor_state_byte
);
   import ring_monitor_pkg::*;
   logic sup1;
   logic sup2;
   assign sup1 = beacon.valid && !beacon.port2 && beacon.src_mac == supervisor_mac;
   assign sup2 = beacon.valid && beacon.port2 && beacon.src_mac == supervisor_mac;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_p1_state_capture: assert property (sup1 |=>
      port1_supervisor_state_byte == $past(beacon.state_flags)) else $error("p1 state lost");
   chk_p2_state_capture: assert property (sup2 |=>
      port2_supervisor_state_byte == $past(beacon.state_flags)) else $error("p2 state lost");
   chk_p1_change_event: assert property (sup1 &&
      beacon.state_flags != port1_supervisor_state_byte |=> event_flags[0])
      else $error("p1 change flag missing");
   chk_p2_change_event: assert property (sup2 &&
      beacon.state_flags != port2_supervisor_state_byte |=> event_flags[1])
      else $error("p2 change flag missing");
   chk_change_has_cause: assert property ($rose(event_flags[0]) |-> $past(sup1))
      else $error("p1 change flag without beacon");
   chk_foreign_ignored: assert property (beacon.valid &&
      beacon.src_mac != supervisor_mac |=> $stable({port2_supervisor_state_byte,
      port1_supervisor_state_byte})) else $error("foreign beacon changed state");
   chk_state_readback: assert property (reg_req.rd &&
      reg_req.addr == `OFS_BEACON_STATE_PAIR |=> reg_rdata == $past({
      port2_supervisor_state_byte, port1_supervisor_state_byte})) else $error("state read");
   chk_neighbor_record: assert property (neighbor.valid && !neighbor.port2 &&
      !reg_req.wr ##1 !neighbor.valid && !reg_req.wr ##1 !neighbor.valid && reg_req.rd &&
      reg_req.addr == `OFS_P1_NBR_SRC_0 |=>
      reg_rdata == $past(neighbor.src_mac[15:0], 3)) else $error("neighbor record");
endmodule

bind ring_beacon_supervision_monitor ring_monitor_chk chk_u (.clk, .rst_n, .reg_req,
   .reg_rdata, .beacon, .neighbor, .supervisor_mac, .event_flags,
   .port1_supervisor_state_byte, .port2_supervisor_state_byte);

// ===== tb/ring_rx_model.sv
// Receive path model handing parsed ring frames to the monitor
`timescale 1ns/1ns
module ring_rx_model
(
   input  wire logic                          clk,
   output ring_monitor_pkg::beacon_frame_t   beacon,
   output ring_monitor_pkg::neighbor_frame_t neighbor
);
   import ring_monitor_pkg::*;
   initial
   begin
      beacon = '0;
      neighbor = '0;
   end
   // Idle fields show inverted junk so stale frame data is never mistaken for valid
   task automatic send_beacon(input logic p2, input logic crc, input logic [47:0] mac,
                              input logic [7:0] flags);
      @(posedge clk);
      beacon <= '{1'b1, p2, crc, mac, flags};
      @(posedge clk);
      beacon <= '{1'b0, ~p2, ~crc, ~mac, ~flags};
   endtask
   task automatic send_neighbor(input logic p2, input logic [47:0] mac);
      @(posedge clk);
      neighbor <= '{1'b1, p2, mac};
      @(posedge clk);
      neighbor <= '{1'b0, ~p2, ~mac};
   endtask
endmodule

// ===== tb/ring_beacon_supervision_monitor_tb.sv
// Self-checking bench for the ring beacon supervision monitor
`timescale 1ns/1ns
`include "ring_monitor_defs.svh"
module ring_beacon_supervision_monitor_tb;
   import ring_monitor_pkg::*;
   logic            clk;
   logic            rst_n;
   reg_req_t        reg_req;
   logic [15:0]     reg_rdata;
   beacon_frame_t   beacon;
   neighbor_frame_t neighbor;
   logic [47:0]     supervisor_mac;
   logic [47:0]     mac;
   logic [3:0]      event_flags;
   logic [7:0]      s1;
   logic [7:0]      s2;
   logic [7:0]      e1;
   logic [7:0]      e2;
   logic [7:0]      f;
   logic [15:0]     v;
   logic [15:0]     ch;
   logic [31:0]     seed;
   logic [31:0]     t1;
   logic [31:0]     t2;
   logic            good;
   int              n;
   int              failures;
   int              checks;
   logic [7:0]      offs [11] = '{8'h6e, 8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h7a,
                                  8'h7c, 8'h7e, 8'h80, 8'h90};

   ring_beacon_supervision_monitor dut_u (.clk, .rst_n, .reg_req, .reg_rdata, .beacon,
      .neighbor, .supervisor_mac, .event_flags, .port1_supervisor_state_byte(s1),
      .port2_supervisor_state_byte(s2));
   ring_rx_model rx_u (.clk, .beacon, .neighbor);

   function automatic logic [31:0] next_rand(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [31:0] stamp_gap(input int idle);
      return 32'(idle + 2);
   endfunction

   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic w, input logic r);
      @(posedge clk);
      reg_req <= '{a, d, w, r};
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(a, d, 1'b1, 1'b0);
      bus(8'h00, 16'h0000, 1'b0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      bus(a, 16'h0000, 1'b0, 1'b1);
      bus(8'h00, 16'h0000, 1'b0, 1'b0);
      #1 d = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      rd(a, v);
      cmp(v, e);
   endtask
   // Bounded poll; running out simply leaves the bit clear for the caller to flag
   task automatic poll(input logic [15:0] mask);
      n = 0;
      v = 16'h0000;
      while ((v & mask) == 16'h0000 && n < 40)
      begin
         rd(`OFS_SWITCH_EVENT, v);
         n++;
      end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      close_out();
   end

   initial
   begin
      seed = 32'h0000343f;
      reg_req = '0;
      rst_n = 1'b0;
      seed = next_rand(seed);
      supervisor_mac = {seed[15:0], seed};
      e1 = 8'h00;
      e2 = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h90, 16'hffff);
      foreach (offs[i]) rc(offs[i], 16'h0000);
      seed = next_rand(seed);
      wr(`OFS_TIMEOUT_LOW, seed[15:0]);
      wr(`OFS_TIMEOUT_HIGH, seed[31:16]);
      rc(`OFS_TIMEOUT_LOW, seed[15:0]);
      rc(`OFS_TIMEOUT_HIGH, seed[31:16]);
      for (int i = 0; i < 12; i++)
      begin
         seed = next_rand(seed);
         f = (i == 0) ? 8'h00 : seed[15:8];
         good = seed[1] | seed[2];
         mac = good ? supervisor_mac : supervisor_mac ^ {40'h0, seed[23:16] | 8'h01};
         rx_u.send_beacon(seed[0], seed[3], mac, f);
         ch = 16'h0000;
         if (good)
         begin
            ch = (seed[0] ? 16'h0002 : 16'h0001) & {16{f != (seed[0] ? e2 : e1)}};
            if (seed[0])
               e2 = f;
            else
               e1 = f;
         end
         rc(`OFS_BEACON_STATE_PAIR, {e2, e1});
         cmp({s2, s1}, {e2, e1});
         cmp({12'h000, event_flags}, ch);
         rc(`OFS_SWITCH_EVENT, ch);
      end
      rx_u.send_beacon(1'b0, 1'b1, supervisor_mac, e1);
      repeat (37) @(posedge clk);
      rx_u.send_beacon(1'b1, 1'b0, supervisor_mac, e2);
      rd(`OFS_P1_STAMP_HIGH, t1[31:16]);
      rd(`OFS_P1_STAMP_LOW, t1[15:0]);
      rd(`OFS_P2_STAMP_HIGH, t2[31:16]);
      rd(`OFS_P2_STAMP_LOW, t2[15:0]);
      t2 = t2 - t1;
      cmp(t2[15:0], 16'(stamp_gap(37)));
      cmp(t2[31:16], 16'h0000);
      rc(`OFS_P1_STAMP_LOW, t1[15:0]);
      rd(`OFS_SWITCH_EVENT, v);
      wr(`OFS_TIMEOUT_HIGH, 16'h0000);
      wr(`OFS_TIMEOUT_LOW, 16'h0008);
      for (int p = 0; p < 2; p++)
      begin
         wr(`OFS_RING_CONTROL, 16'h0080 << p);
         repeat (10)
         begin
            rx_u.send_beacon(p[0], 1'b1, supervisor_mac, p[0] ? e2 : e1);
            repeat (4) @(posedge clk);
         end
         rc(`OFS_SWITCH_EVENT, 16'h0000);
         rx_u.send_beacon(p[0], 1'b0, supervisor_mac, p[0] ? e2 : e1);
         poll(16'h0004 << p);
         cmp({15'h0000, n >= 3 && n < 40}, 16'h0001);
         poll(16'h0004 << p);
         cmp({15'h0000, n >= 7 && n <= 11}, 16'h0001);
         wr(`OFS_RING_CONTROL, 16'h0000);
         rd(`OFS_SWITCH_EVENT, v);
         repeat (60) @(posedge clk);
         rc(`OFS_SWITCH_EVENT, 16'h0000);
      end
      seed = next_rand(seed);
      mac = {seed[31:16], seed ^ 32'h5a5a5a5a};
      rx_u.send_neighbor(1'b1, ~mac);
      rx_u.send_neighbor(1'b0, mac);
      rc(`OFS_P1_NBR_SRC_0, mac[15:0]);
      rc(`OFS_P1_NBR_SRC_2, mac[47:32]);
      rc(`OFS_P1_NBR_SRC_1, mac[31:16]);
      wr(`OFS_RING_CONTROL, 16'h0800);
      rc(`OFS_P1_NBR_SRC_1, 16'h0000);
      rc(`OFS_P1_NBR_SRC_0, 16'h0000);
      rc(`OFS_P1_NBR_SRC_2, 16'h0000);
      close_out();
   end
endmodule
